// ===== src/ebp_defs.svh
/*
  register offsets, field positions, reset values and timing counts of the
  eeprom byte program controller. assumes inclusion by bare name.
*/
`ifndef EBP_DEFS_SVH
`define EBP_DEFS_SVH

`define EBP_OFF_ADDR_LO   8'h00
`define EBP_OFF_ADDR_HI   8'h04
`define EBP_OFF_DATA      8'h08
`define EBP_OFF_CTRL      8'h0C
`define EBP_OFF_IRQ_STAT  8'h10
`define EBP_OFF_IRQ_EN    8'h14
`define EBP_OFF_IRQ_CLR   8'h18

`define EBP_CTRL_RD       0
`define EBP_CTRL_STROBE   1
`define EBP_CTRL_MPE      2
`define EBP_CTRL_MODE     4

`define EBP_IRQ_DONE      0
`define EBP_IRQ_REFUSED   1

`define EBP_RST_BYTE      8'h00
`define EBP_RST_MODE      2'h0
`define EBP_RST_IRQ       2'h0

`define EBP_STALL_RD      3'h4
`define EBP_STALL_WR      3'h2
`define EBP_MPE_WINDOW    3'h4

`define EBP_TICKS_ATOMIC  16'h0022
`define EBP_TICKS_ERASE   16'h0012
`define EBP_TICKS_WRITE   16'h0012

`define EBP_RESP_OKAY     2'h0
`define EBP_RESP_SLVERR   2'h2

`endif

// ===== src/ebp_pkg.sv
/*
  types of the eeprom byte program controller.
  assumes nothing of its surroundings.
*/
package ebp_pkg;

  typedef enum logic [1:0] {
    EBP_OP_ATOMIC = 2'b00,
    EBP_OP_ERASE  = 2'b01,
    EBP_OP_WRITE  = 2'b10,
    EBP_OP_NONE   = 2'b11
  } ebp_op_t;

  typedef enum logic [0:0] {
    EBP_TMR_IDLE = 1'b0,
    EBP_TMR_RUN  = 1'b1
  } ebp_tmr_state_t;

endpackage

// ===== src/ebp_byte_mem.sv
/*
  512 x 8 eeprom array with erase, write-only and atomic byte updates.
  assumes one operation at a time from the controller, same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module ebp_byte_mem
  import ebp_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic [8:0] addr,
  input  wire logic       we,
  input  wire ebp_op_t    op,
  input  wire logic [7:0] wdata,
  input  wire logic       rd_en,
  output logic      [7:0] rdata
);
`include "ebp_defs.svh"

  logic [7:0] mem [0:511];
  logic [7:0] wr_only_val;

  assign wr_only_val = mem[addr] & wdata;

  //////////////////////////////////////////////////////////////////////////
  // array update
  always_ff @(posedge aclk) begin
    if (ce && we) begin
      case (op)
        EBP_OP_ATOMIC: mem[addr] <= wdata;
        EBP_OP_ERASE:  mem[addr] <= 8'hFF;
        EBP_OP_WRITE:  mem[addr] <= wr_only_val;
        default:       mem[addr] <= mem[addr];
      endcase
    end
  end

  // registered read port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= `EBP_RST_BYTE;
    end else if (ce && rd_en) begin
      rdata <= mem[addr];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking mem_cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  atomic_store_a: assert property (we && op == EBP_OP_ATOMIC |=> mem[$past(addr)] == $past(wdata))
    else $error("atomic program did not store data byte");
  erase_store_a: assert property (we && op == EBP_OP_ERASE |=> mem[$past(addr)] == 8'hFF)
    else $error("erase did not leave byte erased");
  write_only_a: assert property (we && op == EBP_OP_WRITE |=> mem[$past(addr)] == $past(wr_only_val))
    else $error("write-only did not program over old byte");

endmodule

`default_nettype wire

// ===== src/ebp_op_timer.sv
/*
  self-timed programming duration counter paced by oscillator ticks.
  assumes tick is a one-cycle pulse already synchronised to aclk, ticks >= 1.
*/
`timescale 1ns/1ns
`default_nettype none

module ebp_op_timer
  import ebp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [15:0] ticks,
  input  wire logic        tick,
  output logic             busy,
  output logic             done
);

  ebp_tmr_state_t state_q;
  logic [15:0]    cnt_q;

  assign busy = (state_q == EBP_TMR_RUN);
  assign done = ce & busy & tick & (cnt_q == 16'h0001);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= EBP_TMR_IDLE;
      cnt_q   <= 16'h0000;
    end else if (ce) begin
      case (state_q)
        EBP_TMR_IDLE: begin
          if (start) begin
            state_q <= EBP_TMR_RUN;
            cnt_q   <= ticks;
          end
        end
        EBP_TMR_RUN: begin
          if (tick) begin
            cnt_q <= cnt_q - 16'h0001;
            if (cnt_q == 16'h0001) begin
              state_q <= EBP_TMR_IDLE;
            end
          end
        end
        default: state_q <= EBP_TMR_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking tmr_cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  tick_paced_a: assert property (busy && !tick |=> cnt_q == $past(cnt_q) && busy)
    else $error("programming time advanced without oscillator tick");
  busy_hold_a: assert property (busy && !done |=> busy)
    else $error("busy dropped before operation finished");

endmodule

`default_nettype wire

// ===== src/ebp_ctrl.sv
/*
  eeprom byte program controller: axi4-lite register slave, address and data
  registers, mode field, master enable window, program strobe, cpu stall,
  self-timed erase/write and interrupt. assumes osc_tick comes from the
  calibrated oscillator domain and is synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none

module ebp_ctrl
  import ebp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        osc_tick,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             cpu_stall,
  output logic             irq
);
`include "ebp_defs.svh"
  function automatic logic reg_is(input logic [7:0] a, input logic [7:0] off);
    reg_is = (a[7:2] == off[7:2]);
  endfunction
  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = reg_is(a, `EBP_OFF_ADDR_LO) | reg_is(a, `EBP_OFF_ADDR_HI)
               | reg_is(a, `EBP_OFF_DATA) | reg_is(a, `EBP_OFF_CTRL)
               | reg_is(a, `EBP_OFF_IRQ_STAT) | reg_is(a, `EBP_OFF_IRQ_EN)
               | reg_is(a, `EBP_OFF_IRQ_CLR);
  endfunction

  logic        aw_held_q, w_held_q, wr_wait_q, bvalid_q, rvalid_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] rd_word;
  logic [8:0]  addr_q;
  logic [7:0]  data_q;
  logic [1:0]  mode_q;
  logic [2:0]  mpe_cnt_q;
  logic [2:0]  stall_cnt_q;
  ebp_op_t     op_q;
  logic [1:0]  stat_q;
  logic [1:0]  irq_en_q;
  logic        rd_pend_q, osc_meta_q, osc_sync_q, osc_prev_q;
  logic        wr_fire, lane0, wr_ctrl, wr_data, mpe_set, mpe_active;
  logic        busy, op_done, start_op, rd_go, refused, osc_pulse;
  logic [15:0] op_ticks;
  logic [1:0]  irq_ev;
  ebp_op_t     new_op;
  logic [7:0]  mem_rdata;

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite write side
  assign s_axi_awready = ce & ~aw_held_q;
  assign s_axi_wready  = ce & ~w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_fire       = ce & aw_held_q & w_held_q & ~wr_wait_q & ~bvalid_q;
  assign lane0         = wr_fire & wstrb_q[0];
  assign wr_ctrl       = lane0 & reg_is(awaddr_q, `EBP_OFF_CTRL);
  assign wr_data       = lane0 & reg_is(awaddr_q, `EBP_OFF_DATA);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // response waits out the cpu stall
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_wait_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `EBP_RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        wr_wait_q <= 1'b1;
        bresp_q   <= reg_mapped(awaddr_q) ? `EBP_RESP_OKAY : `EBP_RESP_SLVERR;
      end else if (wr_wait_q && stall_cnt_q == 3'h0) begin
        wr_wait_q <= 1'b0;
        bvalid_q  <= 1'b1;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite read side
  assign s_axi_arready = ce & ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_comb begin
    rd_word = 32'h00000000;
    if (reg_is(s_axi_araddr, `EBP_OFF_ADDR_LO)) begin
      rd_word = {24'h000000, addr_q[7:0]};
    end else if (reg_is(s_axi_araddr, `EBP_OFF_ADDR_HI)) begin
      rd_word = {31'h0000000, addr_q[8]};
    end else if (reg_is(s_axi_araddr, `EBP_OFF_DATA)) begin
      rd_word = {24'h000000, data_q};
    end else if (reg_is(s_axi_araddr, `EBP_OFF_CTRL)) begin
      rd_word = {26'h000000, mode_q, 1'b0, mpe_active, busy, 1'b0};
    end else if (reg_is(s_axi_araddr, `EBP_OFF_IRQ_STAT)) begin
      rd_word = {30'h0000000, stat_q};
    end else if (reg_is(s_axi_araddr, `EBP_OFF_IRQ_EN)) begin
      rd_word = {30'h0000000, irq_en_q};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `EBP_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= reg_mapped(s_axi_araddr) ? `EBP_RESP_OKAY : `EBP_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // operation decode
  assign new_op     = ebp_op_t'(wdata_q[`EBP_CTRL_MODE+1:`EBP_CTRL_MODE]);
  assign mpe_active = (mpe_cnt_q != 3'h0);
  assign mpe_set    = wr_ctrl & wdata_q[`EBP_CTRL_MPE];
  assign start_op   = wr_ctrl & wdata_q[`EBP_CTRL_STROBE] & mpe_active
                    & ~busy & (new_op != EBP_OP_NONE);
  assign rd_go      = wr_ctrl & wdata_q[`EBP_CTRL_RD] & ~wdata_q[`EBP_CTRL_STROBE]
                    & ~busy;
  assign refused    = wr_ctrl & ((wdata_q[`EBP_CTRL_STROBE] & ~start_op)
                    | (wdata_q[`EBP_CTRL_RD] & busy));
  assign cpu_stall  = (stall_cnt_q != 3'h0);

  always_comb begin
    case (new_op)
      EBP_OP_ATOMIC: op_ticks = `EBP_TICKS_ATOMIC;
      EBP_OP_ERASE:  op_ticks = `EBP_TICKS_ERASE;
      EBP_OP_WRITE:  op_ticks = `EBP_TICKS_WRITE;
      default:       op_ticks = `EBP_TICKS_ATOMIC;
    endcase
  end

  // master enable window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mpe_cnt_q <= 3'h0;
    end else if (ce) begin
      if (start_op) begin
        mpe_cnt_q <= 3'h0;
      end else if (mpe_set) begin
        mpe_cnt_q <= `EBP_MPE_WINDOW;
      end else if (mpe_active) begin
        mpe_cnt_q <= mpe_cnt_q - 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stall_cnt_q <= 3'h0;
    end else if (ce) begin
      if (rd_go) begin
        stall_cnt_q <= `EBP_STALL_RD;
      end else if (start_op) begin
        stall_cnt_q <= `EBP_STALL_WR;
      end else if (cpu_stall) begin
        stall_cnt_q <= stall_cnt_q - 3'h1;
      end
    end
  end

  // address, data and mode hold still while programming
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q    <= 9'h000;
      data_q    <= `EBP_RST_BYTE;
      mode_q    <= `EBP_RST_MODE;
      rd_pend_q <= 1'b0;
      op_q      <= EBP_OP_ATOMIC;
    end else if (ce) begin
      rd_pend_q <= rd_go;
      if (lane0 && reg_is(awaddr_q, `EBP_OFF_ADDR_LO) && !busy) begin
        addr_q[7:0] <= wdata_q[7:0];
      end
      if (lane0 && reg_is(awaddr_q, `EBP_OFF_ADDR_HI) && !busy) begin
        addr_q[8] <= wdata_q[0];
      end
      if (rd_pend_q) begin
        data_q <= mem_rdata;
      end else if (wr_data && !busy) begin
        data_q <= wdata_q[7:0];
      end
      if (wr_ctrl && !busy) begin
        mode_q <= wdata_q[`EBP_CTRL_MODE+1:`EBP_CTRL_MODE];
      end
      if (start_op) begin
        op_q <= new_op;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // oscillator tick synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_meta_q <= 1'b0;
      osc_sync_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else if (ce) begin
      osc_meta_q <= osc_tick;
      osc_sync_q <= osc_meta_q;
      osc_prev_q <= osc_sync_q;
    end
  end

  assign osc_pulse = osc_sync_q & ~osc_prev_q;

  ebp_op_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .start   (start_op),
    .ticks   (op_ticks),
    .tick    (osc_pulse),
    .busy    (busy),
    .done    (op_done)
  );

  ebp_byte_mem u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .addr    (addr_q),
    .we      (op_done),
    .op      (op_q),
    .wdata   (data_q),
    .rd_en   (rd_go),
    .rdata   (mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // interrupt status, set wins over clear
  assign irq_ev[`EBP_IRQ_DONE]    = op_done;
  assign irq_ev[`EBP_IRQ_REFUSED] = refused;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_stat
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          stat_q[gi] <= 1'b0;
        end else if (ce) begin
          if (irq_ev[gi]) begin
            stat_q[gi] <= 1'b1;
          end else if (lane0 && reg_is(awaddr_q, `EBP_OFF_IRQ_CLR) && wdata_q[gi]) begin
            stat_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_q <= `EBP_RST_IRQ;
    end else if (ce && lane0 && reg_is(awaddr_q, `EBP_OFF_IRQ_EN)) begin
      irq_en_q <= wdata_q[1:0];
    end
  end

  assign irq = |(stat_q & irq_en_q);

  //////////////////////////////////////////////////////////////////////////
  default clocking ctrl_cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  read_stall_a: assert property (rd_go |=> cpu_stall[*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");
  write_stall_a: assert property (start_op |=> cpu_stall[*2] ##1 !cpu_stall)
    else $error("write stall not two cycles");
  start_gate_a: assert property (start_op |-> $past(mpe_set) || $past(mpe_set, 2)
    || $past(mpe_set, 3) || $past(mpe_set, 4))
    else $error("operation started outside master enable window");
  mpe_expire_a: assert property (mpe_set ##1 (!mpe_set)[*4] |=> !mpe_active)
    else $error("master enable outlived its window");
  strobe_hold_a: assert property (start_op |=> busy && cpu_stall)
    else $error("strobe not set after start");
  strobe_clear_a: assert property ($fell(busy) |-> $past(op_done))
    else $error("strobe cleared without operation end");
  refuse_busy_a: assert property (busy |-> !start_op && !rd_go && !$changed(addr_q))
    else $error("eeprom operation accepted while busy");
  read_data_a: assert property (rd_go |-> ##2 data_q == $past(mem_rdata) && cpu_stall)
    else $error("read byte not in data register during stall");
  op_mode_a: assert property (start_op |=> op_q == $past(new_op) && op_q != EBP_OP_NONE)
    else $error("operation mode not latched at start");
  data_write_a: assert property (wr_data && !busy && !rd_pend_q |=> data_q == $past(wdata_q[7:0]))
    else $error("data register write lost");

endmodule

`default_nettype wire

// ===== verification/ebp_ctrl_tb_top.sv
/*
  self-checking testbench of the eeprom byte program controller: drives the
  axi4-lite register port and the oscillator tick, checks stall, busy, data and irq.
  assumes the design files under src/ and ebp_defs.svh on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ebp_defs.svh"

module ebp_ctrl_tb_top
  import ebp_pkg::*;
;
  logic        aclk;
  logic        aresetn;
  logic        ce;
  logic        osc_tick;
  logic        osc_run;
  logic        osc_div;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        cpu_stall;
  logic        irq;
  int          errors;
  int          compares;
  int          stall_cnt;
  int          tick_cnt;

  ebp_ctrl dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .osc_tick(osc_tick),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .cpu_stall(cpu_stall), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // oscillator tick: two cycles high, two low, stoppable
  always @(posedge aclk) begin
    if (osc_run) begin
      osc_div <= ~osc_div;
      if (osc_div) begin
        osc_tick <= ~osc_tick;
        if (!osc_tick) tick_cnt <= tick_cnt + 1;
      end
    end
  end

  always @(posedge aclk) begin
    if (cpu_stall === 1'b1) stall_cnt <= stall_cnt + 1;
  end

  initial begin
    repeat (30000) @(posedge aclk);
    errors++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    cmp("bresp", {30'h0, `EBP_RESP_OKAY}, {30'h0, r});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_rd(a, d, r);
    cmp("rresp", {30'h0, `EBP_RESP_OKAY}, {30'h0, r});
  endtask

  task automatic prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d,
                      input int gap);
    wr(`EBP_OFF_ADDR_LO, {24'h0, a[7:0]});
    wr(`EBP_OFF_ADDR_HI, {31'h0, a[8]});
    wr(`EBP_OFF_DATA, {24'h0, d});
    wr(`EBP_OFF_CTRL, {26'h0, m, 4'h4});
    repeat (gap) @(posedge aclk);
    stall_cnt = 0;
    wr(`EBP_OFF_CTRL, {26'h0, m, 4'h2});
  endtask

  task automatic wait_idle;
    logic [31:0] v;
    v = 32'h2;
    while (v[1] !== 1'b0) rd(`EBP_OFF_CTRL, v);
  endtask

  task automatic rd_byte(input logic [8:0] a, input logic [7:0] e);
    logic [31:0] v;
    wr(`EBP_OFF_ADDR_LO, {24'h0, a[7:0]});
    wr(`EBP_OFF_ADDR_HI, {31'h0, a[8]});
    stall_cnt = 0;
    wr(`EBP_OFF_CTRL, 32'h1);
    cmp("read stall cycles", 32'h4, stall_cnt);
    rd(`EBP_OFF_DATA, v);
    cmp("read byte", {24'h0, e}, v);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] v;
    logic [1:0]  r;
    for (int i = 0; i <= 8'h18; i += 4) begin
      rd(i[7:0], v);
      cmp("reset value", 32'h0, v);
    end
    cmp("irq after reset", 32'h0, {31'h0, irq});
    axi_rd(8'h1C, v, r);
    cmp("unmapped rresp", {30'h0, `EBP_RESP_SLVERR}, {30'h0, r});
    axi_wr(8'h1C, 32'h0, r);
    cmp("unmapped bresp", {30'h0, `EBP_RESP_SLVERR}, {30'h0, r});
    ce <= 1'b0;
    @(posedge aclk);
    cmp("ready while frozen", 32'h0, {29'h0, s_axi_awready, s_axi_wready, s_axi_arready});
    ce <= 1'b1;
  endtask

  task automatic t_ops;
    logic [31:0] v;
    int t0;
    prog(2'b00, 9'h1A5, 8'hC3, 0);
    t0 = tick_cnt;
    cmp("program stall cycles", 32'h2, stall_cnt);
    rd(`EBP_OFF_CTRL, v);
    cmp("strobe busy", 32'h1, {31'h0, v[1]});
    wait_idle();
    compares++;
    if (tick_cnt - t0 < `EBP_TICKS_ATOMIC - 1
        || tick_cnt - t0 > `EBP_TICKS_ATOMIC + 3) begin
      errors++;
      $display("unexpected atomic ticks: expected %0d, seen %0d", `EBP_TICKS_ATOMIC,
               tick_cnt - t0);
    end
    rd_byte(9'h1A5, 8'hC3);
    prog(2'b01, 9'h1A5, 8'h00, 0);
    wait_idle();
    rd_byte(9'h1A5, 8'hFF);
    prog(2'b10, 9'h1A5, 8'h5A, 0);
    wait_idle();
    rd_byte(9'h1A5, 8'h5A);
  endtask

  task automatic t_refused;
    logic [31:0] v;
    for (int k = 0; k < 2; k++) begin
      wr(`EBP_OFF_IRQ_CLR, 32'h3);
      if (k == 0) prog(2'b00, 9'h033, 8'h44, 4);
      else prog(2'b11, 9'h033, 8'h44, 0);
      cmp("refused stall", 32'h0, stall_cnt);
      rd(`EBP_OFF_CTRL, v);
      cmp("refused busy", 32'h0, {31'h0, v[1]});
      rd(`EBP_OFF_IRQ_STAT, v);
      cmp("refused flag", 32'h2, v);
    end
  endtask

  task automatic t_busy;
    logic [31:0] v;
    osc_run = 1'b0;
    prog(2'b00, 9'h0F0, 8'hA7, 0);
    repeat (200) @(posedge aclk);
    rd(`EBP_OFF_CTRL, v);
    cmp("busy with osc stopped", 32'h1, {31'h0, v[1]});
    wr(`EBP_OFF_IRQ_CLR, 32'h3);
    wr(`EBP_OFF_DATA, 32'h11);
    wr(`EBP_OFF_CTRL, 32'h1);
    wr(`EBP_OFF_CTRL, 32'h14);
    wr(`EBP_OFF_CTRL, 32'h12);
    rd(`EBP_OFF_IRQ_STAT, v);
    cmp("busy refusal flag", 32'h2, v);
    osc_run = 1'b1;
    wait_idle();
    rd(`EBP_OFF_DATA, v);
    cmp("data kept while busy", 32'hA7, v);
    rd_byte(9'h0F0, 8'hA7);
  endtask

  task automatic t_irq;
    logic [31:0] v;
    wr(`EBP_OFF_IRQ_CLR, 32'h3);
    prog(2'b01, 9'h100, 8'h00, 0);
    wait_idle();
    cmp("irq masked", 32'h0, {31'h0, irq});
    rd(`EBP_OFF_IRQ_STAT, v);
    cmp("done flag", 32'h1, v);
    wr(`EBP_OFF_IRQ_EN, 32'h1);
    cmp("irq enabled", 32'h1, {31'h0, irq});
    rd(`EBP_OFF_IRQ_CLR, v);
    cmp("clear reads zero", 32'h0, v);
    wr(`EBP_OFF_IRQ_CLR, 32'h1);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    rd(`EBP_OFF_IRQ_STAT, v);
    cmp("status cleared", 32'h0, v);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    compares = 0;
    stall_cnt = 0;
    tick_cnt = 0;
    aresetn = 1'b0;
    ce = 1'b1;
    osc_tick = 1'b0;
    osc_div = 1'b0;
    osc_run = 1'b1;
    s_axi_awvalid = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    s_axi_bready = 1'b1;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_rready = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_ops();
    t_refused();
    t_busy();
    t_irq();
    stop_test();
  end
endmodule

`default_nettype wire
